// ==== rcat_regs.sv ====
// radio core scan, allowlist, cipher and rf test register bank
// Behaviour
// - nine-bit writable scan back-off initial value in bits 24:16
// - nine-bit writable scan upper limit in scan register bits 8:0
// - sixteen-bit writable start address of the public allowlist
// - sixteen-bit writable start address of the private allowlist
// - counts register: private entries in 15:8, public entries in 7:0
// - writing one to the start bit launches one 128-bit cipher operation
// - start bit clears itself at the completion event, masked or not
// - key built from four words, lowest offset holds bits 31:0
// - cipher block fetched from memory at the sixteen-bit block pointer
// - read-only tx and rx integrity codes valid at completion event
// - top bit of rf test control holds receive window open forever
// - endless transmit bit sends normal start then payload without end
// - endless payload without prbs repeats pattern of descriptor or test length bytes, as length select picks
// - length select picks descriptor length or test length up to 511
// - prbs kind bit picks nine-stage or fifteen-stage sequence
// - nine-stage generator is 1+x^5+x^9 seeded with all ones
// - fifteen-stage generator is 1+x^2+x^12+x^13+x^14+x^15 seeded all ones
// - payload select picks memory payload or prbs generator
// - nine-bit test length field gives tx packet length in bytes
`include "rcat_defines.svh"

module rcat_regs #(
	parameter int ADDR_W = 32,
	parameter int LEN_W  = 9
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_write_in,
	input  wire logic              reg_read_in,
	output logic      [31:0]       reg_rdata_out,
	// cipher engine and memory fetch
	output logic      [15:0]       mem_addr_out,
	output logic                   mem_req_out,
	input  wire logic [31:0]       mem_data_in,
	input  wire logic              mem_ack_in,
	input  wire logic [31:0]       tx_mic_in,
	input  wire logic [31:0]       rx_mic_in,
	output logic      [127:0]      cipher_key_out,
	output logic                   cipher_done_irq_out,
	// link layer controls
	output logic      [LEN_W-1:0]  scan_init_a_out,
	output logic      [LEN_W-1:0]  scan_upper_limit_out,
	output logic      [15:0]       allowlist_public_start_out,
	output logic      [15:0]       allowlist_private_start_out,
	output logic      [7:0]        private_entry_count_out,
	output logic      [7:0]        public_entry_count_out,
	output logic                   endless_rx_window_out,
	// rf test transmit payload path
	input  wire logic [LEN_W-1:0]  descriptor_adv_length_in,
	input  wire logic [7:0]        mem_payload_in,
	input  wire logic              tx_start_in,
	input  wire logic              tx_byte_take_in,
	output logic      [7:0]        tx_byte_out,
	output logic                   tx_active_out,
	output logic      [LEN_W-1:0]  tx_length_out
);

	// ==================================================================
	// state
	typedef struct packed {
		logic [LEN_W-1:0]             scan_init_a;
		logic [LEN_W-1:0]             scan_upper_limit;
		logic [15:0]                  pub_start;
		logic [15:0]                  priv_start;
		logic [7:0]                   priv_count;
		logic [7:0]                   pub_count;
		logic                         start;
		logic [127:0]                 key;
		logic [15:0]                  blk_addr;
		logic [31:0]                  tx_mic;
		logic [31:0]                  rx_mic;
		logic                         rx_endless;
		logic                         tx_endless;
		logic                         len_sel;
		logic                         prbs_kind;
		logic                         pld_sel;
		logic [LEN_W-1:0]             test_len;
		rcat_pkg::rcat_cipher_state_t cst;
		logic [7:0]                   ccount;
		logic [1:0]                   fetch_idx;
		logic                         mem_req;
		logic [15:0]                  mem_addr;
		logic                         irq;
		logic [31:0]                  rdata;
		logic [8:0]                   lfsr9;
		logic [14:0]                  lfsr15;
		logic                         tx_act;
		logic [LEN_W-1:0]             byte_cnt;
		logic [LEN_W-1:0]             tx_len;
		logic [7:0]                   tx_byte;
	} rcat_state_t;

	rcat_state_t st;
	rcat_state_t next_st;

	// ==================================================================
	// next-state logic
	always_comb begin
		logic [7:0]       prbs_byte;
		logic [8:0]       l9;
		logic [14:0]      l15;
		logic [LEN_W-1:0] eff_len;
		logic             last_byte;
		prbs_byte = 8'h00;
		eff_len   = '0;
		last_byte = 1'b0;
		l9        = st.lfsr9;
		l15       = st.lfsr15;
		next_st   = st;
		next_st.irq = 1'b0;
		next_st.rdata = `RCAT_RESET_WORD;

		// register writes; reserved bits are simply not stored
		if (reg_write_in) begin
			unique case (reg_addr_in)
			`RCAT_OFS_SCAN: begin
				next_st.scan_init_a = reg_wdata_in[`RCAT_SCAN_INIT_LSB +: LEN_W];
				next_st.scan_upper_limit = reg_wdata_in[LEN_W-1:0];
			end
			`RCAT_OFS_PUB_PTR:  next_st.pub_start = reg_wdata_in[15:0];
			`RCAT_OFS_PRIV_PTR: next_st.priv_start = reg_wdata_in[15:0];
			`RCAT_OFS_COUNTS: begin
				next_st.priv_count = reg_wdata_in[15:8];
				next_st.pub_count  = reg_wdata_in[7:0];
			end
			`RCAT_OFS_CIPH_CTRL: begin
				// a zero write does not abort a running operation
				if (reg_wdata_in[`RCAT_START_BIT])
					next_st.start = 1'b1;
			end
			`RCAT_OFS_KEY0: next_st.key[31:0]   = reg_wdata_in;
			`RCAT_OFS_KEY1: next_st.key[63:32]  = reg_wdata_in;
			`RCAT_OFS_KEY2: next_st.key[95:64]  = reg_wdata_in;
			`RCAT_OFS_KEY3: next_st.key[127:96] = reg_wdata_in;
			`RCAT_OFS_BLK_PTR: next_st.blk_addr = reg_wdata_in[15:0];
			`RCAT_OFS_RF_TEST: begin
				next_st.rx_endless = reg_wdata_in[`RCAT_RX_ENDLESS_BIT];
				next_st.tx_endless = reg_wdata_in[`RCAT_TX_ENDLESS_BIT];
				next_st.len_sel    = reg_wdata_in[`RCAT_LEN_SEL_BIT];
				next_st.prbs_kind  = reg_wdata_in[`RCAT_PRBS_KIND_BIT];
				next_st.pld_sel    = reg_wdata_in[`RCAT_PLD_SEL_BIT];
				next_st.test_len   = reg_wdata_in[LEN_W-1:0];
			end
			default: ;
			endcase
		end

		// register reads; unmapped addresses and reserved bits give zero
		if (reg_read_in) begin
			unique case (reg_addr_in)
			`RCAT_OFS_SCAN: begin
				next_st.rdata[`RCAT_SCAN_INIT_LSB +: LEN_W] = st.scan_init_a;
				next_st.rdata[LEN_W-1:0] = st.scan_upper_limit;
			end
			`RCAT_OFS_PUB_PTR:  next_st.rdata[15:0] = st.pub_start;
			`RCAT_OFS_PRIV_PTR: next_st.rdata[15:0] = st.priv_start;
			`RCAT_OFS_COUNTS: next_st.rdata[15:0] = {st.priv_count, st.pub_count};
			`RCAT_OFS_CIPH_CTRL: next_st.rdata[`RCAT_START_BIT] = st.start;
			`RCAT_OFS_KEY0: next_st.rdata = st.key[31:0];
			`RCAT_OFS_KEY1: next_st.rdata = st.key[63:32];
			`RCAT_OFS_KEY2: next_st.rdata = st.key[95:64];
			`RCAT_OFS_KEY3: next_st.rdata = st.key[127:96];
			`RCAT_OFS_BLK_PTR: next_st.rdata[15:0] = st.blk_addr;
			`RCAT_OFS_TX_MIC: next_st.rdata = st.tx_mic;
			`RCAT_OFS_RX_MIC: next_st.rdata = st.rx_mic;
			`RCAT_OFS_RF_TEST: begin
				next_st.rdata[`RCAT_RX_ENDLESS_BIT] = st.rx_endless;
				next_st.rdata[`RCAT_TX_ENDLESS_BIT] = st.tx_endless;
				next_st.rdata[`RCAT_LEN_SEL_BIT]    = st.len_sel;
				next_st.rdata[`RCAT_PRBS_KIND_BIT]  = st.prbs_kind;
				next_st.rdata[`RCAT_PLD_SEL_BIT]    = st.pld_sel;
				next_st.rdata[LEN_W-1:0]            = st.test_len;
			end
			default: ;
			endcase
		end

		// ==============================================================
		// cipher sequencer: fetch four words of the block, then wait
		unique case (st.cst)
		rcat_pkg::RCAT_IDLE: begin
			if (st.start) begin
				next_st.cst       = rcat_pkg::RCAT_FETCH;
				next_st.fetch_idx = 2'h0;
				next_st.mem_req   = 1'b1;
			end
		end
		rcat_pkg::RCAT_FETCH: begin
			if (mem_ack_in) begin
				next_st.fetch_idx = st.fetch_idx + 2'h1;
				if (st.fetch_idx == 2'h3) begin
					next_st.mem_req = 1'b0;
					next_st.cst     = rcat_pkg::RCAT_CRYPT;
					next_st.ccount  = `RCAT_CIPHER_CYCLES;
				end
			end
		end
		rcat_pkg::RCAT_CRYPT: begin
			next_st.ccount = st.ccount - 8'h01;
			if (st.ccount == 8'h01)
				next_st.cst = rcat_pkg::RCAT_DONE;
		end
		rcat_pkg::RCAT_DONE: begin
			// results latch with the event, independent of any mask
			next_st.irq    = 1'b1;
			next_st.start  = 1'b0;
			next_st.tx_mic = tx_mic_in;
			next_st.rx_mic = rx_mic_in;
			next_st.cst    = rcat_pkg::RCAT_IDLE;
		end
		endcase

		// ==============================================================
		// rf test payload generator
		if (st.len_sel)
			eff_len = st.test_len;
		else
			eff_len = descriptor_adv_length_in;
		last_byte = (st.byte_cnt + 1'b1 == eff_len);

		for (int i = 0; i < 8; i++) begin
			if (st.prbs_kind) begin
				prbs_byte[i] = l15[14];
				l15 = {l15[13:0], l15[14] ^ l15[13] ^ l15[12] ^
					l15[11] ^ l15[1]};
			end else begin
				prbs_byte[i] = l9[8];
				l9 = {l9[7:0], l9[8] ^ l9[4]};
			end
		end

		if (tx_start_in) begin
			next_st.tx_act   = 1'b1;
			next_st.byte_cnt = '0;
			next_st.tx_len   = eff_len;
			next_st.lfsr9    = `RCAT_PRBS9_SEED;
			next_st.lfsr15   = `RCAT_PRBS15_SEED;
		end else if (st.tx_act && tx_byte_take_in) begin
			if (st.pld_sel) begin
				next_st.tx_byte = prbs_byte;
				next_st.lfsr9   = l9;
				next_st.lfsr15  = l15;
			end else begin
				next_st.tx_byte = mem_payload_in;
			end
			next_st.byte_cnt = st.byte_cnt + 1'b1;
			if (last_byte) begin
				// endless mode wraps the pattern instead of stopping
				next_st.byte_cnt = '0;
				if (!st.tx_endless)
					next_st.tx_act = 1'b0;
			end
		end

		// fetch address held in a flop so the port never glitches
		next_st.mem_addr = next_st.blk_addr +
			{12'h000, next_st.fetch_idx, 2'h0};
	end

	// ==================================================================
	// state register; every field resets to zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ==================================================================
	// outputs straight from flops
	assign reg_rdata_out               = st.rdata;
	assign mem_addr_out                = st.mem_addr;
	assign mem_req_out                 = st.mem_req;
	assign cipher_key_out              = st.key;
	assign cipher_done_irq_out         = st.irq;
	assign scan_init_a_out             = st.scan_init_a;
	assign scan_upper_limit_out        = st.scan_upper_limit;
	assign allowlist_public_start_out  = st.pub_start;
	assign allowlist_private_start_out = st.priv_start;
	assign private_entry_count_out     = st.priv_count;
	assign public_entry_count_out      = st.pub_count;
	assign endless_rx_window_out       = st.rx_endless;
	assign tx_byte_out                 = st.tx_byte;
	assign tx_active_out               = st.tx_act;
	assign tx_length_out               = st.tx_len;

endmodule

// ==== rcat_defines.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef RCAT_DEFINES_SVH
`define RCAT_DEFINES_SVH

// ======================================================================
// register offsets
`define RCAT_OFS_SCAN       32'h400000A4
`define RCAT_OFS_PUB_PTR    32'h400000B0
`define RCAT_OFS_PRIV_PTR   32'h400000B4
`define RCAT_OFS_COUNTS     32'h400000B8
`define RCAT_OFS_CIPH_CTRL  32'h400000C0
`define RCAT_OFS_KEY0       32'h400000C4
`define RCAT_OFS_KEY1       32'h400000C8
`define RCAT_OFS_KEY2       32'h400000CC
`define RCAT_OFS_KEY3       32'h400000D0
`define RCAT_OFS_BLK_PTR    32'h400000D4
`define RCAT_OFS_TX_MIC     32'h400000D8
`define RCAT_OFS_RX_MIC     32'h400000DC
`define RCAT_OFS_RF_TEST    32'h400000E0

// ======================================================================
// field positions
`define RCAT_SCAN_INIT_LSB  16
`define RCAT_START_BIT      0
`define RCAT_RX_ENDLESS_BIT 31
`define RCAT_TX_ENDLESS_BIT 15
`define RCAT_LEN_SEL_BIT    14
`define RCAT_PRBS_KIND_BIT  13
`define RCAT_PLD_SEL_BIT    12

// ======================================================================
// reset and seed values
`define RCAT_RESET_WORD     32'h00000000
`define RCAT_PRBS9_SEED     9'h1FF
`define RCAT_PRBS15_SEED    15'h7FFF

// ======================================================================
// timing: cipher engine latency, in clock cycles
`define RCAT_CIPHER_CYCLES  8'h40

`endif

// ==== rcat_pkg.sv ====
// types shared by the radio core register bank
package rcat_pkg;

	typedef enum logic [1:0] {
		RCAT_IDLE,
		RCAT_FETCH,
		RCAT_CRYPT,
		RCAT_DONE
	} rcat_cipher_state_t;

endpackage

// ==== rcat_monitor.sv ====
// port checker for the radio core register bank
`include "rcat_defines.svh"
module rcat_monitor #(
	parameter int ADDR_W = 32,
	parameter int LEN_W  = 9
) (
	// clock, reset and register port
	input wire logic              clk_in,
	input wire logic              rst_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0]       reg_wdata_in,
	input wire logic              reg_write_in,
	input wire logic              reg_read_in,
	input wire logic [31:0]       reg_rdata_out,
	// cipher side
	input wire logic [15:0]       mem_addr_out,
	input wire logic              mem_req_out,
	input wire logic [127:0]      cipher_key_out,
	input wire logic              cipher_done_irq_out,
	// link layer and tx side
	input wire logic [LEN_W-1:0]  scan_init_a_out,
	input wire logic [LEN_W-1:0]  scan_upper_limit_out,
	input wire logic [7:0]        private_entry_count_out,
	input wire logic [7:0]        public_entry_count_out,
	input wire logic              endless_rx_window_out,
	input wire logic [LEN_W-1:0]  descriptor_adv_length_in,
	input wire logic              tx_start_in,
	input wire logic              tx_active_out,
	input wire logic [LEN_W-1:0]  tx_length_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ==================================================================
	// shadow copies of the fields the checks depend on
	logic [15:0]      blk;
	logic             sel;
	logic [LEN_W-1:0] len;
	wire              wr_s = reg_write_in;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			blk <= 16'h0000;
			sel <= 1'b0;
			len <= '0;
		end else if (wr_s && reg_addr_in == `RCAT_OFS_BLK_PTR) begin
			blk <= reg_wdata_in[15:0];
		end else if (wr_s && reg_addr_in == `RCAT_OFS_RF_TEST) begin
			sel <= reg_wdata_in[14];
			len <= reg_wdata_in[LEN_W-1:0];
		end
	end
	// ==================================================================
	// cipher sequence, register field and tx length checks
	sequence s_start;
		wr_s && reg_addr_in == `RCAT_OFS_CIPH_CTRL && reg_wdata_in[0];
	endsequence
	sequence s_done;
		##[1:80] cipher_done_irq_out;
	endsequence
	a_fetch_start: assert property (s_start |-> ##2 mem_req_out)
		else $error("fetch did not follow start");
	a_fetch_addr: assert property ($rose(mem_req_out) |->
		mem_addr_out == blk) else $error("fetch address wrong");
	a_done_after: assert property ($fell(mem_req_out) |-> s_done)
		else $error("completion missing");
	a_irq_pulse: assert property (cipher_done_irq_out |=>
		!cipher_done_irq_out) else $error("completion not one cycle");
	a_rdata_idle: assert property (!$past(reg_read_in) |->
		reg_rdata_out == 32'h00000000) else $error("read data not idle");
	a_key_low: assert property (wr_s && reg_addr_in == `RCAT_OFS_KEY0
		|=> cipher_key_out[31:0] == $past(reg_wdata_in))
		else $error("key low word");
	a_key_high: assert property (wr_s && reg_addr_in == `RCAT_OFS_KEY3
		|=> cipher_key_out[127:96] == $past(reg_wdata_in))
		else $error("key high word");
	a_scan_fields: assert property (wr_s && reg_addr_in == `RCAT_OFS_SCAN
		|=> scan_init_a_out == $past(reg_wdata_in[24:16])
		&& scan_upper_limit_out == $past(reg_wdata_in[8:0]))
		else $error("scan fields");
	a_count_fields: assert property (wr_s && reg_addr_in == `RCAT_OFS_COUNTS
		|=> private_entry_count_out == $past(reg_wdata_in[15:8])
		&& public_entry_count_out == $past(reg_wdata_in[7:0]))
		else $error("count fields");
	a_rx_window: assert property (wr_s && reg_addr_in == `RCAT_OFS_RF_TEST
		|=> endless_rx_window_out == $past(reg_wdata_in[31]))
		else $error("rx window bit");
	a_tx_length: assert property (tx_start_in |=> tx_active_out
		&& tx_length_out == (sel ? len : $past(descriptor_adv_length_in)))
		else $error("tx length");
endmodule

// ==== rcat_regs_tb.sv ====
// self-checking bench for the radio core register bank
`include "rcat_defines.svh"
module rcat_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// stimulus and observation
	logic         clk_in = 1'b0;
	logic         rst_in = 1'b1;
	logic [31:0]  addr = '0, wdata = '0, rdata, tx_mic = '0, rx_mic = '0;
	logic         wr_s = 0, rd_s = 0, mem_ack = 0, irq, mem_req, txs = 0;
	logic         take = 0, tact;
	logic [15:0]  mem_addr;
	logic [127:0] key;
	logic [8:0]   desc = 9'h025, tlen;
	logic [7:0]   payload = 8'h5A, tbyte;
	int           miscompares = 0;
	int           n_checks = 0;
	int           i, j, k;
	// address, write data, read back
	logic [95:0]  rows [13] = '{
		{`RCAT_OFS_SCAN, 32'hFFFFFFFF, 32'h01FF01FF},
		{`RCAT_OFS_PUB_PTR, 32'hFFFFFFFF, 32'h0000FFFF},
		{`RCAT_OFS_PRIV_PTR, 32'hA5A51234, 32'h00001234},
		{`RCAT_OFS_COUNTS, 32'hFFFF7E81, 32'h00007E81},
		{`RCAT_OFS_KEY0, 32'h11111111, 32'h11111111},
		{`RCAT_OFS_KEY1, 32'h22222222, 32'h22222222},
		{`RCAT_OFS_KEY2, 32'h33333333, 32'h33333333},
		{`RCAT_OFS_KEY3, 32'h44444444, 32'h44444444},
		{`RCAT_OFS_BLK_PTR, 32'hFFFF0040, 32'h00000040},
		{`RCAT_OFS_TX_MIC, 32'hFFFFFFFF, 32'h00000000},
		{`RCAT_OFS_RX_MIC, 32'hFFFFFFFF, 32'h00000000},
		{`RCAT_OFS_RF_TEST, 32'hFFFFFFFF, 32'h8000F1FF},
		{32'h400000A8, 32'hFFFFFFFF, 32'h00000000}};
	// control, length, first byte, still active after three bytes
	logic [33:0]  txr [6] = '{{16'h5002, 9'h002, 8'hFF, 1'b0},
		{16'hC002, 9'h002, 8'h5A, 1'b1},
		{16'h7002, 9'h002, 8'hFF, 1'b0}, {16'hD002, 9'h002, 8'hFF, 1'b1},
		{16'h4002, 9'h002, 8'h5A, 1'b0}, {16'h1000, 9'h025, 8'hFF, 1'b1}};

	always #12.5 clk_in = ~clk_in;

	rcat_regs dut (.clk_in, .rst_in, .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .mem_addr_out(mem_addr),
		.mem_req_out(mem_req), .mem_data_in(32'h00000000),
		.mem_ack_in(mem_ack), .tx_mic_in(tx_mic), .rx_mic_in(rx_mic),
		.cipher_key_out(key), .cipher_done_irq_out(irq),
		.scan_init_a_out(), .scan_upper_limit_out(),
		.allowlist_public_start_out(), .allowlist_private_start_out(),
		.private_entry_count_out(), .public_entry_count_out(),
		.endless_rx_window_out(), .descriptor_adv_length_in(desc),
		.mem_payload_in(payload), .tx_start_in(txs),
		.tx_byte_take_in(take), .tx_byte_out(tbyte),
		.tx_active_out(tact), .tx_length_out(tlen));

	// ==================================================================
	// shared tasks
	task automatic chk(string n, logic [127:0] got, logic [127:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(logic [31:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic do_reset(int n);
		rst_in <= 1'b1;
		repeat (n) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==================================================================
	// main sequence
	initial begin
		logic [31:0] d;
		do_reset(12);
		foreach (rows[i]) begin
			rd(rows[i][95:64], d);
			chk("reset value", d, 32'h0);
		end
		foreach (rows[i]) begin
			wr(rows[i][95:64], rows[i][63:32]);
			rd(rows[i][95:64], d);
			chk("read back", d, rows[i][31:0]);
		end
		chk("key", key, {4{32'h0}} | 128'h44444444333333332222222211111111);
		$display("register test done");
		@(posedge clk_in);
		tx_mic <= 32'hCAFE0001;
		rx_mic <= 32'hBEEF0002;
		wr(`RCAT_OFS_CIPH_CTRL, 32'h00000001);
		rd(`RCAT_OFS_CIPH_CTRL, d);
		chk("start bit", d, 32'h1);
		chk("fetch addr", mem_addr, 16'h0040);
		k = 0;
		for (i = 0; i < 400 && irq !== 1'b1; i++) begin
			@(posedge clk_in);
			mem_ack <= mem_req && k < 4 && !mem_ack;
			if (mem_req && k < 4 && !mem_ack)
				k++;
		end
		mem_ack <= 1'b0;
		if (i == 400)
			miscompares++;
		if (i == 400)
			conclude();
		rd(`RCAT_OFS_CIPH_CTRL, d);
		chk("start bit", d, 32'h0);
		rd(`RCAT_OFS_TX_MIC, d);
		chk("tx code", d, 32'hCAFE0001);
		rd(`RCAT_OFS_RX_MIC, d);
		chk("rx code", d, 32'hBEEF0002);
		$display("cipher test done");
		foreach (txr[j]) begin
			do_reset(2);
			wr(`RCAT_OFS_RF_TEST, {16'h0000, txr[j][33:18]});
			@(posedge clk_in);
			txs <= 1'b1;
			@(posedge clk_in);
			txs <= 1'b0;
			#1 chk("tx length", tlen, txr[j][17:9]);
			for (k = 0; k < 3; k++) begin
				@(posedge clk_in);
				take <= 1'b1;
				@(posedge clk_in);
				take <= 1'b0;
				#1 if (k == 0)
					chk("tx byte", tbyte, txr[j][8:1]);
			end
			repeat (2) @(posedge clk_in);
			#1 chk("tx active", tact, txr[j][0]);
		end
		$display("tx test done");
		conclude();
	end
endmodule

bind rcat_regs rcat_monitor #(.ADDR_W(ADDR_W), .LEN_W(LEN_W)) mon (.clk_in,
	.rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
	.reg_rdata_out, .mem_addr_out, .mem_req_out, .cipher_key_out,
	.cipher_done_irq_out, .scan_init_a_out, .scan_upper_limit_out,
	.private_entry_count_out, .public_entry_count_out,
	.endless_rx_window_out, .descriptor_adv_length_in, .tx_start_in,
	.tx_active_out, .tx_length_out);
